// >>> pkg/rcl_defines.svh
// Purpose: constants of the reset cause logger
// Assumes: byte-wide register port, 20-bit register address
// Notes: offsets, field positions, reset values, timing counts
//
// Notes on behaviour
// - any reset but power-on keeps cause status contents, only sets the current cause flag
// - power-on reset sets cause bit 0
// - watchdog overflow reset sets cause bit 2
// - supervisor reset sets cause bit 3; power-on value undefined
// - low detector reset sets cause bit 4; power-on value undefined
// - external pin low gives system reset, no flag, status unchanged
// - break instruction resets only the CPU and both enables; memory, other registers, status kept
// - second watchdog overflow resets, the first does not
// - supervisor reset off after init, on when select bit written 1
// - low detector starts disabled, enabled by clearing its disable bit
// - system reset beats all other processing and aborts it
// - power circuit initialised for every cause but break
// - registers with defined initial value reloaded; on break only supervisor select and detector disable
// - all CPU registers initialised for every cause
// - stack pointer loaded from program words 0000H and 0001H
// - PC from 0002H/0003H; break at level 1 or lower uses 0004H/0005H
// - data memory never initialised by any reset
// - supervisor and detector resets keep own enable; others disable both
`ifndef RCL_DEFINES_SVH
`define RCL_DEFINES_SVH
`define RCL_AW            20
`define RCL_OFF_CAUSE     20'h0_F00C
`define RCL_OFF_BLK45     20'h0_F06D
`define RCL_OFF_SUPV      20'h0_F0A0
`define RCL_OFF_ISTAT     20'h0_F0B0
`define RCL_OFF_IMASK     20'h0_F0B1
`define RCL_BIT_POR       0
`define RCL_BIT_WDT       2
`define RCL_BIT_VLS       3
`define RCL_BIT_LLD       4
`define RCL_CAUSE_MASK    8'h1D
`define RCL_CAUSE_RST     8'h01
`define RCL_BLK45_RST     8'h04
`define RCL_BIT_LLD_DIS   2
`define RCL_BIT_SUPV_EN   0
`define RCL_EV_POR        0
`define RCL_EV_PIN        1
`define RCL_EV_WDT        2
`define RCL_EV_VLS        3
`define RCL_EV_LLD        4
`define RCL_EV_BRK        5
`define RCL_EV_WARN       6
`define RCL_EV_MASK       8'h7F
`define RCL_VEC_SP        16'h0000
`define RCL_VEC_PC        16'h0002
`define RCL_VEC_PC_BRK    16'h0004
`define RCL_BRK_LVL_MAX   2'h1
`define RCL_CLK_NS        20
`define RCL_HOLD_NS       200
`define RCL_HOLD_CYC      ((`RCL_HOLD_NS + `RCL_CLK_NS - 1) / `RCL_CLK_NS)
`endif

// >>> pkg/rcl_pkg.sv
// Purpose: types of the reset cause logger
// Assumes: nothing beyond the defines header
// Notes: causes in priority order, sequencer states
`default_nettype none
package rcl_pkg;
    typedef enum logic [2:0] {
        CAUSE_POR, CAUSE_PIN, CAUSE_LLD, CAUSE_VLS, CAUSE_WDT, CAUSE_BRK
    } rcl_cause_t;
    typedef enum logic [2:0] {
        ST_RUN, ST_HOLD, ST_SP_LO, ST_SP_HI, ST_PC_LO, ST_PC_HI, ST_LAST
    } rcl_state_t;
endpackage : rcl_pkg
`default_nettype wire

// >>> rtl/rcl_sync.sv
// Purpose: two-stage synchroniser for pin levels
// Assumes: inputs asynchronous to clk
// Notes: first stage read only by the second
`timescale 1ns/100ps
`default_nettype none
module rcl_sync #(
    parameter int       W       = 3,
    parameter logic [2:0] RST_VAL = 3'h1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= RST_VAL[W-1:0];
            q    <= RST_VAL[W-1:0];
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : rcl_sync
`default_nettype wire

// >>> rtl/rcl_wdog_gate.sv
// Purpose: passes the second watchdog overflow on as a reset request
// Assumes: ovf and clr are one-cycle pulses on clk
// Notes: count restarts on clear and during system reset
`timescale 1ns/100ps
`default_nettype none
module rcl_wdog_gate (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ovf,
    input  wire logic clr,
    input  wire logic hold,
    output var  logic first,
    output var  logic second
);
    logic armed;
    logic live;

    assign live = ovf & ~clr & ~hold;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            armed <= 1'b0;
        end else if (hold || clr) begin
            armed <= 1'b0;
        end else if (ovf) begin
            armed <= 1'b1;
        end
    end

    // first overflow only warns, second one resets
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first  <= 1'b0;
            second <= 1'b0;
        end else begin
            first  <= live & ~armed;
            second <= live & armed;
        end
    end
endmodule : rcl_wdog_gate
`default_nettype wire

// >>> rtl/rcl_top.sv
// Purpose: reset generation, cause logging, vector fetch
// Assumes: RESETN is the power-on reset; same-clock pulses
// Notes: RESET_PIN_N, VLS_LOW, LLD_LOW are asynchronous
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "rcl_defines.svh"

module rcl_top
    import rcl_pkg::*;
(
    input  wire logic              MCLK,
    input  wire logic              RESETN,
    input  wire logic              RESET_PIN_N,
    input  wire logic              WDT_OVF,
    input  wire logic              WDT_CLR,
    input  wire logic              VLS_LOW,
    input  wire logic              LLD_LOW,
    input  wire logic              BRK_EXEC,
    input  wire logic [1:0]        BRK_INTERRUPT_LEVEL_FIELD,
    input  wire logic [`RCL_AW-1:0] ADDR,
    input  wire logic [7:0]        WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output var  logic [7:0]        RDATA,
    output logic [15:0]            PM_ADDR,
    output logic                   PM_RD,
    input  wire logic [7:0]        PM_RDATA,
    output logic                   CPU_RESET,
    output logic                   SFR_INIT,
    output logic                   POWER_INIT,
    output var  logic [15:0]       SP_INIT,
    output var  logic [15:0]       PC_INIT,
    output logic                   VLS_ENABLE,
    output logic                   LLD_ENABLE,
    output logic                   IRQ
);

    // ==========================================================
    // functions
    // ==========================================================
    function automatic rcl_cause_t pick(
        input logic pin,
        input logic low_voltage_detector,
        input logic voltage_supervisor,
        input logic wdt
    );
        rcl_cause_t c;
        c = CAUSE_BRK;
        if (pin) begin
            c = CAUSE_PIN;
        end else if (low_voltage_detector) begin
            c = CAUSE_LLD;
        end else if (voltage_supervisor) begin
            c = CAUSE_VLS;
        end else if (wdt) begin
            c = CAUSE_WDT;
        end
        return c;
    endfunction : pick

    function automatic logic [7:0] flag_of(input rcl_cause_t c);
        logic [7:0] f;
        f = 8'h00;
        case (c)
            CAUSE_WDT: f[`RCL_BIT_WDT] = 1'b1;
            CAUSE_VLS: f[`RCL_BIT_VLS] = 1'b1;
            CAUSE_LLD: f[`RCL_BIT_LLD] = 1'b1;
            default:   f = 8'h00;
        endcase
        return f;
    endfunction : flag_of

    function automatic logic [7:0] event_of(input rcl_cause_t c);
        logic [7:0] e;
        e = 8'h00;
        case (c)
            CAUSE_POR: e[`RCL_EV_POR] = 1'b1;
            CAUSE_PIN: e[`RCL_EV_PIN] = 1'b1;
            CAUSE_WDT: e[`RCL_EV_WDT] = 1'b1;
            CAUSE_VLS: e[`RCL_EV_VLS] = 1'b1;
            CAUSE_LLD: e[`RCL_EV_LLD] = 1'b1;
            default:   e[`RCL_EV_BRK] = 1'b1;
        endcase
        return e;
    endfunction : event_of

    // ==========================================================
    // state
    // ==========================================================
    rcl_state_t state;
    rcl_cause_t cause;
    logic [3:0] hold_cnt;
    logic       brk_low;
    logic [7:0] cause_stat;
    logic [7:0] blk45;
    logic [7:0] supv;
    logic [7:0] istat;
    logic [7:0] imask;
    logic [2:0] sync_q;
    logic       pin_low;
    logic       vls_trig;
    logic       lld_trig;
    logic       wdt_warn;
    logic       wdt_req;
    logic       run;
    logic       brk_req;
    logic       trig;
    logic       level_hold;
    rcl_cause_t new_cause;
    logic       enter;
    logic       full_init;
    logic       done;
    logic [15:0] pc_base;
    logic       wr_cause;
    logic       wr_blk45;
    logic       wr_supv;
    logic       wr_istat;
    logic       wr_imask;

    // ==========================================================
    // source conditioning
    // ==========================================================
    rcl_sync #(
        .W       (3),
        .RST_VAL (3'h1)
    ) u_sync (
        .clk   (MCLK),
        .rst_n (RESETN),
        .d     ({LLD_LOW, VLS_LOW, RESET_PIN_N}),
        .q     (sync_q)
    );

    rcl_wdog_gate u_wdog (
        .clk    (MCLK),
        .rst_n  (RESETN),
        .ovf    (WDT_OVF),
        .clr    (WDT_CLR),
        .hold   (CPU_RESET),
        .first  (wdt_warn),
        .second (wdt_req)
    );

    assign pin_low    = ~sync_q[0];
    assign vls_trig   = supv[`RCL_BIT_SUPV_EN] & sync_q[1];
    assign lld_trig   = ~blk45[`RCL_BIT_LLD_DIS] & sync_q[2];
    assign run        = (state == ST_RUN);
    assign brk_req    = BRK_EXEC & run;
    assign trig       = pin_low | lld_trig | vls_trig | wdt_req | brk_req;
    assign level_hold = pin_low | lld_trig | vls_trig;
    assign new_cause  = pick(pin_low, lld_trig, vls_trig, wdt_req);
    // entry aborts any state, fetch included
    assign enter      = trig;
    assign full_init  = enter && (new_cause != CAUSE_BRK);
    assign done       = (state == ST_LAST);

    // ==========================================================
    // sequencer
    // ==========================================================
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state    <= ST_HOLD;
            cause    <= CAUSE_POR;
            hold_cnt <= 4'(`RCL_HOLD_CYC);
            brk_low  <= 1'b0;
        end else if (enter) begin
            state    <= ST_HOLD;
            cause    <= new_cause;
            hold_cnt <= 4'(`RCL_HOLD_CYC);
            brk_low  <= (new_cause == CAUSE_BRK)
                        && (BRK_INTERRUPT_LEVEL_FIELD <= `RCL_BRK_LVL_MAX);
        end else begin
            case (state)
                ST_HOLD: begin
                    if (hold_cnt != 4'h0) begin
                        hold_cnt <= hold_cnt - 4'h1;
                    end else if (!level_hold) begin
                        state <= ST_SP_LO;
                    end
                end
                ST_SP_LO: state <= ST_SP_HI;
                ST_SP_HI: state <= ST_PC_LO;
                ST_PC_LO: state <= ST_PC_HI;
                ST_PC_HI: state <= ST_LAST;
                ST_LAST:  state <= ST_RUN;
                default:  state <= ST_RUN;
            endcase
        end
    end

    // ==========================================================
    // vector fetch
    // ==========================================================
    assign pc_base = brk_low ? `RCL_VEC_PC_BRK : `RCL_VEC_PC;

    always_comb begin
        PM_RD   = 1'b1;
        PM_ADDR = 16'h0000;
        case (state)
            ST_SP_LO: PM_ADDR = `RCL_VEC_SP;
            ST_SP_HI: PM_ADDR = `RCL_VEC_SP + 16'h0001;
            ST_PC_LO: PM_ADDR = pc_base;
            ST_PC_HI: PM_ADDR = pc_base + 16'h0001;
            default:  PM_RD   = 1'b0;
        endcase
    end

    // data answers one cycle after each read
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            SP_INIT <= 16'h0000;
            PC_INIT <= 16'h0000;
        end else if (!enter) begin
            case (state)
                ST_SP_HI: SP_INIT[7:0]  <= PM_RDATA;
                ST_PC_LO: SP_INIT[15:8] <= PM_RDATA;
                ST_PC_HI: PC_INIT[7:0]  <= PM_RDATA;
                ST_LAST:  PC_INIT[15:8] <= PM_RDATA;
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // reset outputs
    // ==========================================================
    // CPU held for every cause
    assign CPU_RESET  = ~run;
    // peripherals and power only when not a break; no memory clear
    assign SFR_INIT   = ~run && (cause != CAUSE_BRK);
    assign POWER_INIT = ~run && (cause != CAUSE_BRK);
    assign VLS_ENABLE = supv[`RCL_BIT_SUPV_EN];
    assign LLD_ENABLE = ~blk45[`RCL_BIT_LLD_DIS];

    // ==========================================================
    // register port
    // ==========================================================
    always_comb begin
        wr_cause = 1'b0;
        wr_blk45 = 1'b0;
        wr_supv  = 1'b0;
        wr_istat = 1'b0;
        wr_imask = 1'b0;
        if (!WR) begin
            wr_cause = 1'b0;
        end else if (ADDR == `RCL_OFF_CAUSE) begin
            wr_cause = 1'b1;
        end else if (ADDR == `RCL_OFF_BLK45) begin
            wr_blk45 = 1'b1;
        end else if (ADDR == `RCL_OFF_SUPV) begin
            wr_supv  = 1'b1;
        end else if (ADDR == `RCL_OFF_ISTAT) begin
            wr_istat = 1'b1;
        end else if (ADDR == `RCL_OFF_IMASK) begin
            wr_imask = 1'b1;
        end
    end

    // cause flags: survive every reset but power-on, only the cause is or-ed in
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            cause_stat <= `RCL_CAUSE_RST;
        end else begin
            cause_stat <= ((wr_cause ? WDATA : cause_stat)
                          | (enter ? flag_of(new_cause) : 8'h00))
                          & `RCL_CAUSE_MASK;
        end
    end

    // supervisor select: off after init, kept over its own reset
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            supv <= 8'h00;
        end else if (enter) begin
            if (new_cause != CAUSE_VLS) begin
                supv <= 8'h00;
            end
        end else if (wr_supv) begin
            supv <= WDATA & 8'h01;
        end
    end

    // detector disable: set after init, kept over its own reset
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            blk45 <= `RCL_BLK45_RST;
        end else if (enter) begin
            if (new_cause != CAUSE_LLD) begin
                blk45 <= `RCL_BLK45_RST;
            end else if (full_init) begin
                blk45 <= (`RCL_BLK45_RST & ~8'h04) | (blk45 & 8'h04);
            end
        end else if (wr_blk45) begin
            blk45 <= WDATA;
        end
    end

    // ==========================================================
    // interrupt
    // ==========================================================
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            imask <= 8'h00;
        end else if (full_init) begin
            imask <= 8'h00;
        end else if (wr_imask) begin
            imask <= WDATA & `RCL_EV_MASK;
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            istat <= 8'h00;
        end else begin
            istat <= ((full_init ? 8'h00 : istat & ~(wr_istat ? WDATA : 8'h00))
                     | (done ? event_of(cause) : 8'h00)
                     | (wdt_warn ? 8'h40 : 8'h00))
                     & `RCL_EV_MASK;
        end
    end

    assign IRQ = |(istat & imask);

    // ==========================================================
    // read data
    // ==========================================================
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            RDATA <= 8'h00;
        end else if (!RD) begin
            RDATA <= 8'h00;
        end else if (ADDR == `RCL_OFF_CAUSE) begin
            RDATA <= cause_stat;
        end else if (ADDR == `RCL_OFF_BLK45) begin
            RDATA <= blk45;
        end else if (ADDR == `RCL_OFF_SUPV) begin
            RDATA <= supv;
        end else if (ADDR == `RCL_OFF_ISTAT) begin
            RDATA <= istat;
        end else if (ADDR == `RCL_OFF_IMASK) begin
            RDATA <= imask;
        end else begin
            RDATA <= 8'h00;
        end
    end

endmodule : rcl_top
`default_nettype wire

// >>> verif/rcl_top_sva.sv
// Purpose: concurrent checks on the reset cause logger ports
// Assumes: one clock domain, RESETN asynchronous and active low
// Notes: bound to rcl_top after the module
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// checker
module rcl_top_sva
    import rcl_pkg::*;
(
    input wire logic        MCLK,
    input wire logic        RESETN,
    input wire logic        RESET_PIN_N,
    input wire logic        WDT_OVF,
    input wire logic        VLS_LOW,
    input wire logic        LLD_LOW,
    input wire logic        BRK_EXEC,
    input wire logic [15:0] PM_ADDR,
    input wire logic        PM_RD,
    input wire logic [7:0]  PM_RDATA,
    input wire logic        CPU_RESET,
    input wire logic        SFR_INIT,
    input wire logic        POWER_INIT,
    input wire logic [15:0] SP_INIT,
    input wire logic [15:0] PC_INIT
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    // four vector reads, low byte first, then fetch ends
    sequence s_fetch;
        PM_RD && PM_ADDR == 16'h0000 ##1 PM_RD && PM_ADDR == 16'h0001
        ##1 PM_RD && (PM_ADDR == 16'h0002 || PM_ADDR == 16'h0004)
        ##1 PM_RD && PM_ADDR == $past(PM_ADDR) + 16'h0001 ##1 !PM_RD;
    endsequence
    // break accepted with no other source pending
    sequence s_brk_alone;
        RESET_PIN_N [*3] ##0 (BRK_EXEC && !CPU_RESET && !WDT_OVF && !$past(WDT_OVF) && !VLS_LOW && !LLD_LOW);
    endsequence

    a_fetch_order: assert property ($rose(PM_RD) |-> s_fetch)
        else $error("vector fetch address order wrong");
    a_vector_load: assert property ($rose(PM_RD) |-> ##5 (SP_INIT == {$past(PM_RDATA, 3), $past(PM_RDATA, 4)}
        && PC_INIT == {$past(PM_RDATA, 1), $past(PM_RDATA, 2)}))
        else $error("loaded vectors differ from fetched bytes");
    a_fetch_in_reset: assert property (PM_RD |-> CPU_RESET)
        else $error("vector fetch outside reset");
    a_init_pair: assert property ((SFR_INIT || POWER_INIT) |-> (CPU_RESET && SFR_INIT && POWER_INIT))
        else $error("register and power init disagree");
    a_pin_reset: assert property (!RESET_PIN_N [*5] |-> CPU_RESET)
        else $error("pin low without system reset");
    a_reset_hold: assert property ($rose(CPU_RESET) |-> CPU_RESET [*8])
        else $error("system reset too short");
    a_brk_skip_init: assert property (s_brk_alone |=> CPU_RESET && !SFR_INIT && !POWER_INIT)
        else $error("break reset wrong init");
    a_nonbrk_init: assert property ($rose(CPU_RESET) && !$past(BRK_EXEC) |-> SFR_INIT)
        else $error("non-break reset without init");
    a_fetch_end: assert property ($fell(CPU_RESET) |-> $past(PM_RD, 2) && !$past(PM_RD))
        else $error("reset ended without vector fetch");
endmodule : rcl_top_sva

bind rcl_top rcl_top_sva rcl_top_sva_inst (
    .MCLK(MCLK), .RESETN(RESETN), .RESET_PIN_N(RESET_PIN_N), .WDT_OVF(WDT_OVF),
    .VLS_LOW(VLS_LOW), .LLD_LOW(LLD_LOW), .BRK_EXEC(BRK_EXEC), .PM_ADDR(PM_ADDR),
    .PM_RD(PM_RD), .PM_RDATA(PM_RDATA), .CPU_RESET(CPU_RESET), .SFR_INIT(SFR_INIT),
    .POWER_INIT(POWER_INIT), .SP_INIT(SP_INIT), .PC_INIT(PC_INIT)
);
`default_nettype wire

// >>> verif/rcl_pmem_model.sv
// Purpose: program memory seen by the vector fetch
// Assumes: byte answered the cycle after a read
// Notes: byte k holds BASE + k
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// model
module rcl_pmem_model #(
    parameter logic [7:0] BASE = 8'hA0
) (
    input  wire logic        clk,
    input  wire logic        rd,
    input  wire logic [15:0] addr,
    output var  logic [7:0]  data
);
    initial data = 8'h5A;
    always @(posedge clk) begin
        if (rd) begin
            data <= BASE + addr[7:0];
        end else begin
            // idle: toggles so a stale byte never looks valid
            data <= ~data;
        end
    end
endmodule : rcl_pmem_model
`default_nettype wire

// >>> verif/rcl_top_tb.sv
// Purpose: self-checking bench of the reset cause logger
// Assumes: register port with read data one cycle later
// Notes: vectors come from the program memory model
`timescale 1ns/100ps
`default_nettype none
`include "rcl_defines.svh"
// ==========================================================
// bench
module rcl_top_tb;
    import rcl_pkg::*;
    localparam logic [7:0] PM_BASE = 8'hA0;
    logic              MCLK = 1'b0;
    logic              RESETN = 1'b0;
    logic              RESET_PIN_N = 1'b1;
    logic              WDT_OVF = 1'b0;
    logic              WDT_CLR = 1'b0;
    logic              VLS_LOW = 1'b0;
    logic              LLD_LOW = 1'b0;
    logic              BRK_EXEC = 1'b0;
    logic [1:0]        BRK_INTERRUPT_LEVEL_FIELD = 2'h0;
    logic [`RCL_AW-1:0] ADDR = '0;
    logic [7:0]        WDATA = 8'h00;
    logic              WR = 1'b0;
    logic              RD = 1'b0;
    logic [7:0]        RDATA, PM_RDATA;
    logic [15:0]       PM_ADDR, SP_INIT, PC_INIT;
    logic              PM_RD, CPU_RESET, SFR_INIT, POWER_INIT, VLS_ENABLE, LLD_ENABLE, IRQ;
    int                n_errors = 0;
    int                n_tests = 0;

    rcl_top rcl_top_inst (.MCLK, .RESETN, .RESET_PIN_N, .WDT_OVF, .WDT_CLR, .VLS_LOW, .LLD_LOW,
        .BRK_EXEC, .BRK_INTERRUPT_LEVEL_FIELD, .ADDR, .WDATA, .WR, .RD, .RDATA, .PM_ADDR, .PM_RD, .PM_RDATA,
        .CPU_RESET, .SFR_INIT, .POWER_INIT, .SP_INIT, .PC_INIT, .VLS_ENABLE, .LLD_ENABLE, .IRQ);
    rcl_pmem_model #(.BASE(PM_BASE)) rcl_pmem_model_inst (.clk(MCLK), .rd(PM_RD), .addr(PM_ADDR),
        .data(PM_RDATA));

    always #10 MCLK = ~MCLK;

    function automatic logic [15:0] vec(input logic [7:0] k);
        return {PM_BASE + k + 8'h01, PM_BASE + k};
    endfunction : vec

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask : wr

    task automatic rd(input string n, input logic [19:0] a, input logic [7:0] e);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        #1 chk(n, 16'(RDATA), 16'(e));
    endtask : rd

    // waits for a whole reset pass, then checks the loaded stack pointer
    task automatic wait_rst();
        int i;
        i = 0;
        while (CPU_RESET !== 1'b1 && i < 20) begin
            @(posedge MCLK);
            i++;
        end
        while (CPU_RESET !== 1'b0 && i < 120) begin
            @(posedge MCLK);
            i++;
        end
        chk("cpu_reset", 16'(CPU_RESET), 16'h0000);
        @(negedge MCLK);
        chk("sp", SP_INIT, vec(8'h00));
    endtask : wait_rst

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    initial begin
        // about 300 cycles of tests; fifty times that is a hang
        #300_000;
        n_errors++;
        results();
    end

    initial begin
        repeat (16) @(posedge MCLK);
        RESETN <= 1'b1;
        wait_rst();
        chk("pc", PC_INIT, vec(8'h02));
        chk("vls_en", 16'(VLS_ENABLE), 16'h0000);
        chk("lld_en", 16'(LLD_ENABLE), 16'h0000);
        chk("irq_masked", 16'(IRQ), 16'h0000);
        rd("cause_por", `RCL_OFF_CAUSE, 8'h01);
        rd("blk45", `RCL_OFF_BLK45, `RCL_BLK45_RST);
        wr(`RCL_OFF_IMASK, 8'h01);
        @(negedge MCLK);
        chk("irq_set", 16'(IRQ), 16'h0001);
        wr(`RCL_OFF_ISTAT, 8'h01);
        @(negedge MCLK);
        chk("irq_clr", 16'(IRQ), 16'h0000);
        wr(`RCL_OFF_CAUSE, 8'h00);
        rd("cause_clr", `RCL_OFF_CAUSE, 8'h00);
        wr(`RCL_OFF_CAUSE, 8'hE2);
        rd("cause_rsvd", `RCL_OFF_CAUSE, 8'h00);
        rd("unmapped", 20'h0_F00D, 8'h00);
        $display("end of test power_on");
        // overflow, clear, overflow: still first of a fresh count
        for (int k = 0; k < 4; k++) begin
            @(posedge MCLK);
            WDT_OVF <= (k != 1);
            WDT_CLR <= (k == 1);
            @(posedge MCLK);
            WDT_OVF <= 1'b0;
            WDT_CLR <= 1'b0;
            if (k == 2) begin
                repeat (20) @(posedge MCLK);
                chk("wdt_first", 16'(CPU_RESET), 16'h0000);
            end
        end
        wait_rst();
        rd("cause_wdt", `RCL_OFF_CAUSE, 8'h04);
        $display("end of test watchdog");
        wr(`RCL_OFF_IMASK, 8'h01);
        @(posedge MCLK);
        RESET_PIN_N <= 1'b0;
        repeat (6) @(posedge MCLK);
        RESET_PIN_N <= 1'b1;
        wait_rst();
        chk("pc_pin", PC_INIT, vec(8'h02));
        rd("cause_pin", `RCL_OFF_CAUSE, 8'h04);
        rd("imask_init", `RCL_OFF_IMASK, 8'h00);
        $display("end of test pin");
        @(posedge MCLK);
        VLS_LOW <= 1'b1;
        repeat (6) @(posedge MCLK);
        VLS_LOW <= 1'b0;
        repeat (10) @(posedge MCLK);
        chk("vls_off", 16'(CPU_RESET), 16'h0000);
        wr(`RCL_OFF_SUPV, 8'h01);
        @(negedge MCLK);
        chk("vls_on", 16'(VLS_ENABLE), 16'h0001);
        @(posedge MCLK);
        VLS_LOW <= 1'b1;
        repeat (6) @(posedge MCLK);
        VLS_LOW <= 1'b0;
        wait_rst();
        rd("cause_vls", `RCL_OFF_CAUSE, 8'h0C);
        chk("vls_kept", 16'(VLS_ENABLE), 16'h0001);
        $display("end of test supervisor");
        wr(`RCL_OFF_BLK45, 8'h00);
        @(negedge MCLK);
        chk("lld_on", 16'(LLD_ENABLE), 16'h0001);
        @(posedge MCLK);
        LLD_LOW <= 1'b1;
        repeat (6) @(posedge MCLK);
        LLD_LOW <= 1'b0;
        wait_rst();
        rd("cause_lld", `RCL_OFF_CAUSE, 8'h1C);
        chk("lld_kept", 16'(LLD_ENABLE), 16'h0001);
        chk("vls_dropped", 16'(VLS_ENABLE), 16'h0000);
        $display("end of test detector");
        wr(`RCL_OFF_IMASK, 8'h20);
        for (int lvl = 0; lvl < 4; lvl++) begin
            @(posedge MCLK);
            BRK_INTERRUPT_LEVEL_FIELD <= 2'(lvl);
            BRK_EXEC <= 1'b1;
            @(posedge MCLK);
            BRK_EXEC <= 1'b0;
            wait_rst();
            chk("pc_brk", PC_INIT, (lvl <= 1) ? vec(8'h04) : vec(8'h02));
            chk("lld_brk", 16'(LLD_ENABLE), 16'h0000);
            chk("irq_brk", 16'(IRQ), 16'h0001);
            rd("cause_brk", `RCL_OFF_CAUSE, 8'h1C);
            rd("imask_brk", `RCL_OFF_IMASK, 8'h20);
            wr(`RCL_OFF_ISTAT, 8'h20);
            @(negedge MCLK);
            chk("irq_brk_clr", 16'(IRQ), 16'h0000);
        end
        $display("end of test break");
        results();
    end
endmodule : rcl_top_tb
`default_nettype wire
